/* core/rs_exception_unit.sv */
// Reset and machine check exception entry with AXI4-Lite register access.
// Assumes pins are asynchronous, parity strobes come from core_clk logic.
//
// Overview of operation
// RL1: Either reset pin raises nonmaskable reset exception
// RL2: Reset saves next instruction address
// RL3: Reset saves MACHINE_STATE_REGISTER bits 0,5-9,16-31; clears others
// RL4: Corrupted state clears saved recoverable bit
// RL5: Soft reset keeps architected registers intact
// RL6: Reset vectors to offset 0x00100
// RL7: Parity, transfer error or pin raise machine check
// RL8: Config bits 0-3 gate each source; transfer error is not gated
// RL9: Enabled and ME taken, else checkstop
// RL10: Checkstop halts processing until reset
// RL11: Transfer error accepted on own bus operations
// RL12: Memory controller reports parity/ECC via transfer error
// RL13: Machine check saves executing instruction address
// RL14: Machine check clears 0-9, sets cache/pin bits
// RL15: Bus parity bits 13-15, copy 16-29,31
// RL16: Machine check with ME cleared checkstops
// RL17: Machine check vectors to offset 0x00200
// RL18: Entry copies INTERRUPT_LITTLE_ENDIAN to LE, clears mode bits
// RL19: Prefix bit selects low or high base
// RL20: Checkstop freezes latches within two cycles
// RL21: Simultaneous sources all set status bits; the code sets no status bit for a transfer error
`timescale 1ns/10ps
`default_nettype none
module rs_exception_unit
  import rs_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input  wire logic              core_clk,
  input  wire logic              rst_n,
  // Board pins
  input  wire logic              soft_reset_n,
  input  wire logic              hard_reset_n,
  input  wire logic              machine_check_pin_n,
  input  wire logic              transfer_error_ack_n,
  // Core-side error strobes and addresses
  input  wire logic              busOpActive,
  input  wire logic              dcacheParityErr,
  input  wire logic              icacheParityErr,
  input  wire logic              addrParityErr,
  input  wire logic              dataParityErr,
  input  wire logic              stateCorrupt,
  input  wire logic [31:0]       nextInstrAddr,
  input  wire logic [31:0]       execInstrAddr,
  // Fetch redirect and status
  output logic                   fetchRedirect,
  output logic      [31:0]       fetchAddr,
  output logic                   checkstop,
  output logic      [31:0]       machineState,
  // AXI4-Lite slave
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic      [1:0]        s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic      [31:0]       s_axi_rdata,
  output logic      [1:0]        s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready
);

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisation and event detection

  logic [3:0]  pinLevel;
  logic [3:0]  pinPrev_reg;
  logic        softFell;
  logic        hardFell;
  logic        resetTake;
  logic        teaEvt;
  logic [4:0]  mcSrc;
  logic        mcReq;
  logic        mcTake;
  logic        stopTake;
  rs_cause_t   cause;
  logic [31:0] calcMsrIn;
  logic [31:0] calcMsr;
  logic [31:0] calcSrr1;

  rs_pin_sync #(
    .WIDTH     (4),
    .RESET_VAL (4'hf)
  ) u_sync (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .pinIn    ({transfer_error_ack_n, machine_check_pin_n, hard_reset_n, soft_reset_n}),
    .levelOut (pinLevel)
  );

  logic [31:0] exception_return_address_reg, exception_return_address_next;
  logic [31:0] exception_saved_state_reg, exception_saved_state_next;
  logic [31:0] hardware_config_zero_reg, hardware_config_zero_next;
  logic [31:0] msr_reg, msr_next;
  logic        stop_reg, stop_next;
  rs_cause_t   lastCause_reg, lastCause_next;
  logic        redir_reg, redir_next;
  logic [31:0] fetch_reg, fetch_next;

  always_comb begin
    softFell  = pinPrev_reg[0] & ~pinLevel[0];
    hardFell  = pinPrev_reg[1] & ~pinLevel[1];
    resetTake = softFell | hardFell;  // see RL1
    teaEvt    = pinPrev_reg[3] & ~pinLevel[3] & busOpActive;  // see RL11
    mcSrc[4]  = dcacheParityErr & hardware_config_zero_reg[HID_CACHE_EN];  // see RL8
    mcSrc[3]  = icacheParityErr & hardware_config_zero_reg[HID_CACHE_EN];
    mcSrc[2]  = pinPrev_reg[2] & ~pinLevel[2] & hardware_config_zero_reg[HID_PIN_EN];
    mcSrc[1]  = dataParityErr & hardware_config_zero_reg[HID_DBUS_EN];
    mcSrc[0]  = addrParityErr & hardware_config_zero_reg[HID_ABUS_EN];
    mcReq     = (|mcSrc) | teaEvt;  // see RL7
    mcTake    = mcReq & msr_reg[MSR_ME] & ~stop_reg & ~resetTake;  // see RL9
    stopTake  = mcReq & ~msr_reg[MSR_ME] & ~stop_reg & ~resetTake;  // see RL9 see RL16
    if (resetTake) begin
      cause = CAUSE_RESET;
    end else if (mcTake) begin
      cause = CAUSE_MCHECK;
    end else begin
      cause = CAUSE_NONE;
    end
    calcMsrIn = hardFell ? MSR_POR : msr_reg;
  end

  rs_entry_calc u_calc (
    .cause   (cause),
    .corrupt (stateCorrupt),
    .mcSrc   (mcSrc),
    .msrCur  (calcMsrIn),
    .msrNew  (calcMsr),
    .srr1New (calcSrr1)
  );

  ////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave

  logic              awHeld_reg, awHeld_next;
  logic [ADDR_W-1:0] awAddr_reg, awAddr_next;
  logic              wHeld_reg, wHeld_next;
  logic [31:0]       wData_reg, wData_next;
  logic [3:0]        wStrb_reg, wStrb_next;
  logic              bvalid_reg, bvalid_next;
  logic [1:0]        bresp_reg, bresp_next;
  logic              awready_reg, awready_next;
  logic              wready_reg, wready_next;
  logic              arready_reg, arready_next;
  logic              rvalid_reg, rvalid_next;
  logic [31:0]       rdata_reg, rdata_next;
  logic [1:0]        rresp_reg, rresp_next;
  logic              doWrite;

  always_comb begin
    awHeld_next = awHeld_reg;
    awAddr_next = awAddr_reg;
    wHeld_next  = wHeld_reg;
    wData_next  = wData_reg;
    wStrb_next  = wStrb_reg;
    bvalid_next = bvalid_reg;
    bresp_next  = bresp_reg;
    rvalid_next = rvalid_reg;
    rdata_next  = rdata_reg;
    rresp_next  = rresp_reg;
    doWrite     = awHeld_reg & wHeld_reg & ~bvalid_reg;
    if (s_axi_awvalid & awready_reg) begin
      awHeld_next = 1'b1;
      awAddr_next = s_axi_awaddr;
    end
    if (s_axi_wvalid & wready_reg) begin
      wHeld_next = 1'b1;
      wData_next = s_axi_wdata;
      wStrb_next = s_axi_wstrb;
    end
    if (s_axi_bvalid & s_axi_bready) begin
      bvalid_next = 1'b0;
    end
    if (doWrite) begin
      awHeld_next = 1'b0;
      wHeld_next  = 1'b0;
      bvalid_next = 1'b1;
      if (awAddr_reg == OFF_RET_ADDR || awAddr_reg == OFF_SAVED || awAddr_reg == OFF_HWCFG
          || awAddr_reg == OFF_MSR || awAddr_reg == OFF_STATUS) begin
        bresp_next = RESP_OKAY;
      end else begin
        bresp_next = RESP_SLVERR;
      end
    end
    if (s_axi_rvalid & s_axi_rready) begin
      rvalid_next = 1'b0;
    end
    if (s_axi_arvalid & arready_reg) begin
      rvalid_next = 1'b1;
      rresp_next  = RESP_OKAY;
      if (s_axi_araddr == OFF_RET_ADDR) begin
        rdata_next = exception_return_address_reg;
      end else if (s_axi_araddr == OFF_SAVED) begin
        rdata_next = exception_saved_state_reg;
      end else if (s_axi_araddr == OFF_HWCFG) begin
        rdata_next = hardware_config_zero_reg;
      end else if (s_axi_araddr == OFF_MSR) begin
        rdata_next = msr_reg;
      end else if (s_axi_araddr == OFF_STATUS) begin
        rdata_next = {29'h0, lastCause_reg, stop_reg};
      end else begin
        rdata_next = 32'h0;
        rresp_next = RESP_SLVERR;
      end
    end
    awready_next = ~awHeld_next & ~bvalid_next;
    wready_next  = ~wHeld_next & ~bvalid_next;
    arready_next = ~rvalid_next;
  end

  ////////////////////////////////////////////////////////////////////////
  // Architected state and exception entry

  always_comb begin
    exception_return_address_next      = exception_return_address_reg;
    exception_saved_state_next      = exception_saved_state_reg;
    hardware_config_zero_next      = hardware_config_zero_reg;
    msr_next       = msr_reg;
    stop_next      = stop_reg;
    lastCause_next = lastCause_reg;
    redir_next     = 1'b0;
    fetch_next     = fetch_reg;
    if (doWrite & ~stop_reg) begin  // see RL20
      if (awAddr_reg == OFF_RET_ADDR) begin
        exception_return_address_next = rs_merge(exception_return_address_reg, wData_reg, wStrb_reg);
      end else if (awAddr_reg == OFF_SAVED) begin
        exception_saved_state_next = rs_merge(exception_saved_state_reg, wData_reg, wStrb_reg);
      end else if (awAddr_reg == OFF_HWCFG) begin
        hardware_config_zero_next = rs_merge(hardware_config_zero_reg, wData_reg, wStrb_reg);
      end else if (awAddr_reg == OFF_MSR) begin
        msr_next = rs_merge(msr_reg, wData_reg, wStrb_reg);
      end
    end
    if (resetTake) begin
      exception_return_address_next      = nextInstrAddr;  // see RL2
      exception_saved_state_next      = calcSrr1;
      msr_next       = calcMsr;
      stop_next      = 1'b0;  // see RL10
      lastCause_next = CAUSE_RESET;
      redir_next     = 1'b1;
      fetch_next     = rs_vector(calcMsrIn[MSR_IP], VEC_SYS_RESET);  // see RL6 see RL19
      if (hardFell) begin
        hardware_config_zero_next = HARDWARE_CONFIG_ZERO_POR;  // see RL5
      end
    end else if (mcTake) begin
      exception_return_address_next      = execInstrAddr;  // see RL13
      exception_saved_state_next      = calcSrr1;
      msr_next       = calcMsr;
      lastCause_next = CAUSE_MCHECK;
      redir_next     = 1'b1;
      fetch_next     = rs_vector(msr_reg[MSR_IP], VEC_MCHECK);  // see RL17 see RL19
    end else if (stopTake) begin
      stop_next = 1'b1;  // see RL10
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      pinPrev_reg   <= 4'hf;
      exception_return_address_reg      <= WORD_RST;
      exception_saved_state_reg      <= WORD_RST;
      hardware_config_zero_reg      <= HARDWARE_CONFIG_ZERO_POR;
      msr_reg       <= MSR_POR;
      stop_reg      <= 1'b0;
      lastCause_reg <= CAUSE_NONE;
      redir_reg     <= 1'b0;
      fetch_reg     <= WORD_RST;
      awHeld_reg    <= 1'b0;
      awAddr_reg    <= '0;
      wHeld_reg     <= 1'b0;
      wData_reg     <= WORD_RST;
      wStrb_reg     <= 4'h0;
      bvalid_reg    <= 1'b0;
      bresp_reg     <= RESP_OKAY;
      awready_reg   <= 1'b0;
      wready_reg    <= 1'b0;
      arready_reg   <= 1'b0;
      rvalid_reg    <= 1'b0;
      rdata_reg     <= WORD_RST;
      rresp_reg     <= RESP_OKAY;
    end else begin
      pinPrev_reg   <= pinLevel;
      exception_return_address_reg      <= exception_return_address_next;
      exception_saved_state_reg      <= exception_saved_state_next;
      hardware_config_zero_reg      <= hardware_config_zero_next;
      msr_reg       <= msr_next;
      stop_reg      <= stop_next;
      lastCause_reg <= lastCause_next;
      redir_reg     <= redir_next;
      fetch_reg     <= fetch_next;
      awHeld_reg    <= awHeld_next;
      awAddr_reg    <= awAddr_next;
      wHeld_reg     <= wHeld_next;
      wData_reg     <= wData_next;
      wStrb_reg     <= wStrb_next;
      bvalid_reg    <= bvalid_next;
      bresp_reg     <= bresp_next;
      awready_reg   <= awready_next;
      wready_reg    <= wready_next;
      arready_reg   <= arready_next;
      rvalid_reg    <= rvalid_next;
      rdata_reg     <= rdata_next;
      rresp_reg     <= rresp_next;
    end
  end

  assign fetchRedirect = redir_reg;
  assign fetchAddr     = fetch_reg;
  assign checkstop     = stop_reg;
  assign machineState  = msr_reg;
  assign s_axi_awready = awready_reg;
  assign s_axi_wready  = wready_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rdata   = rdata_reg;
  assign s_axi_rresp   = rresp_reg;

  ////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  sequence s_reset_entry;
    resetTake ##1 redir_reg;
  endsequence
  sequence s_mc_entry;
    mcTake ##1 redir_reg;
  endsequence

  property p_reset_vector;
    s_reset_entry |-> fetch_reg[19:0] == VEC_SYS_RESET[19:0]
      && fetch_reg[31:20] == ($past(calcMsrIn[MSR_IP]) ? 12'hfff : 12'h000);
  endproperty
  a_reset_vector: assert property (p_reset_vector) else $error("reset vector wrong");  // see RL6
  property p_mc_vector;
    s_mc_entry |-> fetch_reg[19:0] == VEC_MCHECK[19:0]
      && fetch_reg[31:20] == ($past(msr_reg[MSR_IP]) ? 12'hfff : 12'h000);
  endproperty
  a_mc_vector: assert property (p_mc_vector) else $error("machine check vector wrong");  // see RL17
  property p_reset_exception_return_address;
    resetTake |=> exception_return_address_reg == $past(nextInstrAddr);
  endproperty
  a_reset_exception_return_address: assert property (p_reset_exception_return_address) else $error("return address not saved");  // see RL2
  property p_reset_exception_saved_state;
    softFell && !hardFell |=> (exception_saved_state_reg & ~EXCEPTION_SAVED_STATE_RST_KEEP) == 32'h0
      && (exception_saved_state_reg & 32'h87c0fffd) == ($past(msr_reg) & 32'h87c0fffd);
  endproperty
  a_reset_exception_saved_state: assert property (p_reset_exception_saved_state) else $error("reset saved state wrong");  // see RL3
  property p_ri_clear;
    resetTake && stateCorrupt |=> !exception_saved_state_reg[MSR_RI];
  endproperty
  a_ri_clear: assert property (p_ri_clear) else $error("recoverable bit kept");  // see RL4
  property p_mc_exception_saved_state;
    mcTake |=> exception_saved_state_reg[31:22] == 10'h0 && !exception_saved_state_reg[MSR_RI] && exception_saved_state_reg[0] == $past(msr_reg[0]);
  endproperty
  a_mc_exception_saved_state: assert property (p_mc_exception_saved_state) else $error("machine check saved state wrong");  // see RL14
  property p_checkstop;
    mcReq && !msr_reg[MSR_ME] && !resetTake |=> stop_reg [*2];
  endproperty
  a_checkstop: assert property (p_checkstop) else $error("checkstop not entered");  // see RL16
  property p_freeze;
    stop_reg && !resetTake |=> $stable(msr_reg) && $stable(exception_return_address_reg) && $stable(hardware_config_zero_reg) && !redir_reg;
  endproperty
  a_freeze: assert property (p_freeze) else $error("state changed in checkstop");  // see RL20
  property p_entry_msr;
    (resetTake || mcTake) |=> (msr_reg & MSR_ENTRY_CLEAR & ~32'h1) == 32'h0
      && msr_reg[MSR_LE] == $past(calcMsrIn[MSR_ILE]);
  endproperty
  a_entry_msr: assert property (p_entry_msr) else $error("machine state entry wrong");  // see RL18
  property p_soft_keep;
    softFell && !hardFell && !(doWrite && awAddr_reg == OFF_HWCFG) |=> hardware_config_zero_reg == $past(hardware_config_zero_reg);
  endproperty
  a_soft_keep: assert property (p_soft_keep) else $error("soft reset lost config");  // see RL5

endmodule
`default_nettype wire

/* core/rs_pkg.sv */
// Constants, field positions and types for the reset and machine check unit.
// Assumes a 32-bit register view; bit indices are little-endian (bit 0 = LSB).
package rs_pkg;

  // Register byte offsets on the register bus
  localparam logic [7:0] OFF_RET_ADDR = 8'h00;
  localparam logic [7:0] OFF_SAVED    = 8'h04;
  localparam logic [7:0] OFF_HWCFG    = 8'h08;
  localparam logic [7:0] OFF_MSR      = 8'h0c;
  localparam logic [7:0] OFF_STATUS   = 8'h10;

  // Vector offsets and physical bases
  localparam logic [31:0] VEC_SYS_RESET = 32'h00000100;
  localparam logic [31:0] VEC_MCHECK    = 32'h00000200;
  localparam logic [31:0] BASE_LOW      = 32'h00000000;
  localparam logic [31:0] BASE_HIGH     = 32'hfff00000;

  // Machine state field positions
  localparam int MSR_ILE = 16;
  localparam int MSR_ME  = 12;
  localparam int MSR_IP  = 6;
  localparam int MSR_RI  = 1;
  localparam int MSR_LE  = 0;
  // Power, ext enable, privilege, float, trace, translate, recoverable, LE
  localparam logic [31:0] MSR_ENTRY_CLEAR = 32'h0004ef33;

  // Hardware configuration enables
  localparam int HID_PIN_EN   = 31;
  localparam int HID_CACHE_EN = 30;
  localparam int HID_ABUS_EN  = 29;
  localparam int HID_DBUS_EN  = 28;

  // Saved-state layouts
  localparam logic [31:0] EXCEPTION_SAVED_STATE_RST_KEEP = 32'h87c0ffff;
  localparam logic [31:0] EXCEPTION_SAVED_STATE_MC_KEEP  = 32'h0000fffd;
  localparam logic [31:0] EXCEPTION_SAVED_STATE_DCACHE   = 32'h00200000;
  localparam logic [31:0] EXCEPTION_SAVED_STATE_ICACHE   = 32'h00100000;
  localparam logic [31:0] EXCEPTION_SAVED_STATE_PIN      = 32'h00080000;
  localparam logic [31:0] EXCEPTION_SAVED_STATE_DBUS     = 32'h00060000;
  localparam logic [31:0] EXCEPTION_SAVED_STATE_ABUS     = 32'h00010000;

  // Values after reset
  localparam logic [31:0] MSR_POR  = 32'h00000040;
  localparam logic [31:0] HARDWARE_CONFIG_ZERO_POR = 32'h00000000;
  localparam logic [31:0] WORD_RST = 32'h00000000;

  // Bus answers
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [1:0] {
    CAUSE_NONE   = 2'b00,
    CAUSE_RESET  = 2'b01,
    CAUSE_MCHECK = 2'b10
  } rs_cause_t;

  function automatic logic [31:0] rs_vector(input logic ip, input logic [31:0] off);
    rs_vector = (ip ? BASE_HIGH : BASE_LOW) | off;
  endfunction

  function automatic logic [31:0] rs_merge(input logic [31:0] old, input logic [31:0] data,
                                           input logic [3:0] strb);
    rs_merge = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        rs_merge[8*i +: 8] = data[8*i +: 8];
      end
    end
  endfunction

endpackage

/* core/rs_pin_sync.sv */
// Three-stage synchroniser for active-low pins with agreement filter.
// Assumes inputs are asynchronous to core_clk.
`timescale 1ns/10ps
`default_nettype none
module rs_pin_sync #(
  parameter int          WIDTH     = 4,
  parameter logic [3:0]  RESET_VAL = 4'hf
) (
  // Clock and reset
  input  wire logic             core_clk,
  input  wire logic             rst_n,
  // Pins and filtered levels
  input  wire logic [WIDTH-1:0] pinIn,
  output logic      [WIDTH-1:0] levelOut
);

  logic [WIDTH-1:0] s1_reg;
  logic [WIDTH-1:0] s2_reg;
  logic [WIDTH-1:0] s3_reg;
  logic [WIDTH-1:0] level_reg;
  logic [WIDTH-1:0] level_next;

  always_comb begin
    level_next = level_reg;
    for (int i = 0; i < WIDTH; i++) begin
      if (s2_reg[i] == s3_reg[i]) begin
        level_next[i] = s3_reg[i];
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      s1_reg    <= RESET_VAL[WIDTH-1:0];
      s2_reg    <= RESET_VAL[WIDTH-1:0];
      s3_reg    <= RESET_VAL[WIDTH-1:0];
      level_reg <= RESET_VAL[WIDTH-1:0];
    end else begin
      s1_reg    <= pinIn;
      s2_reg    <= s1_reg;
      s3_reg    <= s2_reg;
      level_reg <= level_next;
    end
  end

  assign levelOut = level_reg;

endmodule
`default_nettype wire

/* core/rs_entry_calc.sv */
// New machine state and saved state on exception entry.
// Assumes a purely combinational use by the exception unit.
`timescale 1ns/10ps
`default_nettype none
module rs_entry_calc
  import rs_pkg::*;
(
  // Exception kind
  input  wire rs_cause_t   cause,
  input  wire logic        corrupt,
  // Machine check sources: dcache, icache, pin, data bus, address bus
  input  wire logic [4:0]  mcSrc,
  // State
  input  wire logic [31:0] msrCur,
  output logic      [31:0] msrNew,
  output logic      [31:0] srr1New
);

  always_comb begin
    msrNew         = msrCur & ~MSR_ENTRY_CLEAR;  // see RL18
    msrNew[MSR_LE] = msrCur[MSR_ILE];            // see RL18
    srr1New        = msrCur;
    case (cause)
      CAUSE_RESET: begin
        srr1New = msrCur & EXCEPTION_SAVED_STATE_RST_KEEP;  // see RL3
        if (corrupt) begin
          srr1New[MSR_RI] = 1'b0;  // see RL4
        end
      end
      CAUSE_MCHECK: begin
        msrNew[MSR_ME] = 1'b0;
        srr1New = (msrCur & EXCEPTION_SAVED_STATE_MC_KEEP)  // see RL14 see RL15
                | (mcSrc[4] ? EXCEPTION_SAVED_STATE_DCACHE : 32'h0)
                | (mcSrc[3] ? EXCEPTION_SAVED_STATE_ICACHE : 32'h0)
                | (mcSrc[2] ? EXCEPTION_SAVED_STATE_PIN : 32'h0)
                | (mcSrc[1] ? EXCEPTION_SAVED_STATE_DBUS : 32'h0)
                | (mcSrc[0] ? EXCEPTION_SAVED_STATE_ABUS : 32'h0);  // see RL21
      end
      default: begin
        msrNew = msrCur;
      end
    endcase
  end

endmodule
`default_nettype wire

/* bench/rs_board_model.sv */
// Board and memory controller model driving the active-low pins.
// Assumes lowReq is a one-cycle request: bit3 soft, bit2 hard, bit1 pin, bit0 error.
`timescale 1ns/10ps
`default_nettype none
module rs_board_model (
  // Clock and pulse requests
  input  wire logic       core_clk,
  input  wire logic [3:0] lowReq,
  // Pins, high while idle
  output logic            soft_reset_n,
  output logic            hard_reset_n,
  output logic            machine_check_pin_n,
  output logic            transfer_error_ack_n
);
  logic [3:0] mask = 4'h0;
  logic [3:0] cnt  = 4'h0;
  ////////////////////////////////////////
  // Low for eight cycles, past the pin filter
  always @(posedge core_clk) begin
    if (lowReq != 4'h0) begin
      mask <= lowReq;
      cnt  <= 4'h8;
    end else if (cnt != 4'h0) begin
      cnt <= cnt - 4'h1;
    end
  end
  // Error acknowledge reports a memory fault on an own access
  assign {soft_reset_n, hard_reset_n, machine_check_pin_n, transfer_error_ack_n} = ~((cnt != 4'h0) ? mask : 4'h0);
endmodule
`default_nettype wire

/* bench/testbench.sv */
// Self-checking bench for the reset and machine check unit.
// Assumes rs_pkg, the design and rs_board_model are compiled first.
`timescale 1ns/10ps
`default_nettype none
module testbench
  import rs_pkg::*;
;
  logic        core_clk = 1'b0, rst_n = 1'b0, busOpActive = 1'b0, stateCorrupt = 1'b0;
  logic [3:0]  lowReq = 4'h0, strb = 4'h0;
  logic [31:0] nextInstrAddr = 32'h0, execInstrAddr = 32'h0, wdata = 32'h0, m, cur;
  logic [7:0]  awaddr = 8'h0, araddr = 8'h0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        softN, hardN, pinN, teaN, fetchRedirect, checkstop;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [31:0] fetchAddr, machineState, rdata;
  logic [1:0]  bresp, rresp;
  logic [63:0] eq[$];
  logic [33:0] rq[$];
  logic [31:0] srcBits [4] = '{EXCEPTION_SAVED_STATE_DCACHE, EXCEPTION_SAVED_STATE_ICACHE, EXCEPTION_SAVED_STATE_ABUS, EXCEPTION_SAVED_STATE_DBUS};
  int          mismatches = 0, compares = 0, cyc = 0;

  rs_exception_unit rs_exception_unit_i (.core_clk(core_clk), .rst_n(rst_n), .soft_reset_n(softN),
    .hard_reset_n(hardN), .machine_check_pin_n(pinN), .transfer_error_ack_n(teaN), .busOpActive(busOpActive),
    .dcacheParityErr(strb[0]), .icacheParityErr(strb[1]), .addrParityErr(strb[2]), .dataParityErr(strb[3]),
    .stateCorrupt(stateCorrupt), .nextInstrAddr(nextInstrAddr), .execInstrAddr(execInstrAddr),
    .fetchRedirect(fetchRedirect), .fetchAddr(fetchAddr), .checkstop(checkstop), .machineState(machineState),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready));
  rs_board_model rs_board_model_i (.core_clk(core_clk), .lowReq(lowReq), .soft_reset_n(softN),
    .hard_reset_n(hardN), .machine_check_pin_n(pinN), .transfer_error_ack_n(teaN));

  initial forever #2.5 core_clk = ~core_clk;
  ////////////////////////////////////////
  function automatic logic [31:0] vec(input logic [31:0] s, input logic [31:0] off);
    return (s[MSR_IP] ? BASE_HIGH : BASE_LOW) | off;
  endfunction
  function automatic logic [31:0] ent(input logic [31:0] s);
    return (s & ~MSR_ENTRY_CLEAR) | {31'h0, s[MSR_ILE]};
  endfunction
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    @(posedge core_clk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge core_clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk(bresp, r);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    @(posedge core_clk);
    rq.push_back({r, d});
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge core_clk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
  endtask
  task automatic settle();
    int n;
    n = 0;
    while (eq.size() != 0 && n < 30) begin
      @(posedge core_clk);
      n++;
    end
    chk(eq.size(), 0);
  endtask
  // One machine check from strobes s or pins p, ME set first
  task automatic mcheck(input logic [3:0] s, input logic [3:0] p, input logic [31:0] bits);
    m = ($urandom & 32'h0005ef33) | 32'h00001000;
    wr(OFF_MSR, m, RESP_OKAY);
    @(posedge core_clk);
    execInstrAddr <= $urandom;
    eq.push_back({vec(m, VEC_MCHECK), ent(m) & ~32'h00001000});
    strb   <= s;
    lowReq <= p;
    @(posedge core_clk);
    strb   <= 4'h0;
    lowReq <= 4'h0;
    settle();
    rd(OFF_SAVED, (m & EXCEPTION_SAVED_STATE_MC_KEEP) | bits, RESP_OKAY);
    rd(OFF_RET_ADDR, execInstrAddr, RESP_OKAY);
  endtask
  ////////////////////////////////////////
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      close_out();
    end
    if (rst_n && fetchRedirect === 1'b1)
      chk({fetchAddr, machineState}, (eq.size() != 0) ? eq.pop_front() : 64'hx);
    if (rvalid === 1'b1 && rready)
      chk({rresp, rdata}, (rq.size() != 0) ? rq.pop_front() : 34'hx);
  end

  initial begin
    void'($urandom(32'ha09a4a4c));
    repeat (5) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge core_clk);
    chk(machineState, MSR_POR);
    rd(OFF_HWCFG, HARDWARE_CONFIG_ZERO_POR, RESP_OKAY);
    rd(8'h14, 32'h0, RESP_SLVERR);
    wr(8'h14, 32'h1, RESP_SLVERR);
    wr(OFF_HWCFG, 32'hf0000000, RESP_OKAY);
    for (int k = 0; k < 4; k++) mcheck(4'h1 << k, 4'h0, srcBits[k]);
    mcheck(4'hf, 4'h0, 32'h00370000);
    mcheck(4'h0, 4'h2, EXCEPTION_SAVED_STATE_PIN);
    busOpActive <= 1'b1;
    mcheck(4'h0, 4'h1, 32'h0);
    busOpActive <= 1'b0;
    cur = ent(m) & ~32'h00001000;
    strb <= 4'h8;
    @(posedge core_clk);
    strb <= 4'h0;
    @(posedge core_clk);
    chk(checkstop, 1'b1);
    rd(OFF_STATUS, {29'h0, CAUSE_MCHECK, 1'b1}, RESP_OKAY);
    wr(OFF_MSR, 32'h00001000, RESP_OKAY);
    rd(OFF_MSR, cur, RESP_OKAY);
    stateCorrupt  <= 1'b1;
    nextInstrAddr <= $urandom;
    eq.push_back({vec(cur, VEC_SYS_RESET), ent(cur)});
    lowReq <= 4'h8;
    @(posedge core_clk);
    lowReq <= 4'h0;
    settle();
    chk(checkstop, 1'b0);
    rd(OFF_SAVED, cur & EXCEPTION_SAVED_STATE_RST_KEEP & ~32'h2, RESP_OKAY);
    rd(OFF_RET_ADDR, nextInstrAddr, RESP_OKAY);
    rd(OFF_HWCFG, 32'hf0000000, RESP_OKAY);
    wr(OFF_MSR, 32'h00001000, RESP_OKAY);
    wr(OFF_HWCFG, 32'h0, RESP_OKAY);
    strb <= 4'hf;
    @(posedge core_clk);
    strb <= 4'h0;
    repeat (8) @(posedge core_clk);
    chk(checkstop, 1'b0);
    stateCorrupt <= 1'b0;
    eq.push_back({vec(MSR_POR, VEC_SYS_RESET), ent(MSR_POR)});
    lowReq <= 4'h4;
    @(posedge core_clk);
    lowReq <= 4'h0;
    settle();
    rd(OFF_HWCFG, HARDWARE_CONFIG_ZERO_POR, RESP_OKAY);
    rd(OFF_SAVED, MSR_POR & EXCEPTION_SAVED_STATE_RST_KEEP, RESP_OKAY);
    rd(OFF_STATUS, {29'h0, CAUSE_RESET, 1'b0}, RESP_OKAY);
    close_out();
  end
endmodule
`default_nettype wire
